// file: pcd_diag_ctl.sv
`timescale 1ns/1ps
`default_nettype none
module pcd_diag_ctl
   import pcd_pkg::*;
#(
   parameter int TIMEOUT_CYC = DIAG_TIMEOUT_CYC
) (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic start_req,
   input wire logic engine_done,
   input wire logic engine_valid,
   input wire logic [1:0] engine_result,
   input wire logic engine_short,
   input wire logic [CNT_W-1:0] engine_count,
   output logic busy,
   output logic engine_start,
   output logic done_evt,
   output logic [1:0] result,
   output logic near_short,
   output logic [CNT_W-1:0] fault_count
);

   // the watchdog counter needs at least one cycle to count down from
   if (TIMEOUT_CYC < 1) begin : g_bad_timeout
      $error("TIMEOUT_CYC must be at least one");
   end

   logic [31:0] wait_reg;
   logic finish;

   // a silent engine must not leave the start bit stuck at one
   assign finish = busy && (engine_done || (wait_reg == 32'h0000_0001));

   always_ff @(posedge clk) begin
      if (!rst_n) begin
         busy <= 1'b0;
         engine_start <= 1'b0;
         wait_reg <= 32'h0000_0000;
      end else begin
         engine_start <= 1'b0;
         if (!busy && start_req) begin
            busy <= 1'b1;
            engine_start <= 1'b1;
            wait_reg <= 32'(TIMEOUT_CYC);
         end else if (finish) begin
            busy <= 1'b0;
            wait_reg <= 32'h0000_0000;
         end else if (busy) begin
            wait_reg <= wait_reg - 32'h0000_0001;
         end
      end
   end

   always_ff @(posedge clk) begin
      if (!rst_n) begin
         done_evt <= 1'b0;
      end else begin
         done_evt <= finish;
      end
   end

   // results only move when a test ends; held until the next one ends
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         result <= RST_RES;
         near_short <= RST_SHORT;
         fault_count <= RST_CNT;
      end else if (finish) begin
         if (engine_done && engine_valid) begin
            result <= engine_result;
            near_short <= engine_short && (engine_result == RES_SHORT);
            fault_count <= engine_count;
         end else begin
            result <= RES_FAILED;
            near_short <= 1'b0;
            fault_count <= RST_CNT;
         end
      end
   end

endmodule
`default_nettype wire

// file: pcd_pkg.sv
package pcd_pkg;

   // register indices; byte address is four times the index
   localparam logic [10:0] IDX_DIAG = 11'h4F0;
   localparam logic [10:0] IDX_SPEC = 11'h4F2;
   localparam logic [10:0] IDX_RSV_LO = 11'h4F8;
   localparam logic [10:0] IDX_RSV_HI = 11'h4FA;
   localparam logic [10:0] IDX_ALIAS = 11'h510;
   localparam logic [10:0] IDX_IRQ_STAT = 11'h600;
   localparam logic [10:0] IDX_IRQ_MASK = 11'h602;

   // cable_diag_ctrl_status fields
   localparam int DIAG_START_BIT = 15;
   localparam int DIAG_RES_LSB = 13;
   localparam int DIAG_SHORT_BIT = 12;
   localparam int DIAG_CNT_LSB = 0;

   // phy_special_ctrl_status fields
   localparam int SPEC_POL_BIT = 5;
   localparam int SPEC_XOVER_BIT = 4;
   localparam int SPEC_FLINK_BIT = 3;
   localparam int SPEC_PSAVE_BIT = 2;
   localparam int SPEC_RLB_BIT = 1;

   // port_special_diag_alias fields
   localparam int ALIAS_SHORT_BIT = 15;
   localparam int ALIAS_RES_LSB = 13;
   localparam int ALIAS_START_BIT = 12;
   localparam int ALIAS_FLINK_BIT = 11;
   localparam int ALIAS_PSAVE_BIT = 10;
   localparam int ALIAS_RLB_BIT = 9;
   localparam int ALIAS_CNT_LSB = 0;

   // interrupt status and mask layout
   localparam int IRQ_DONE_BIT = 0;
   localparam int IRQ_POL_BIT = 1;
   localparam int IRQ_XOVER_BIT = 2;
   localparam int IRQ_W = 3;

   localparam int CNT_W = 9;

   // outcome codes
   localparam logic [1:0] RES_NORMAL = 2'h0;
   localparam logic [1:0] RES_OPEN = 2'h1;
   localparam logic [1:0] RES_SHORT = 2'h2;
   localparam logic [1:0] RES_FAILED = 2'h3;

   // reset values
   localparam logic RST_FLINK = 1'h0;
   localparam logic RST_PSAVE_DIS = 1'h1;
   localparam logic RST_RLB = 1'h0;
   localparam logic [1:0] RST_RES = 2'h0;
   localparam logic RST_SHORT = 1'h0;
   localparam logic [CNT_W-1:0] RST_CNT = 9'h000;
   localparam logic [IRQ_W-1:0] RST_IRQ = 3'h0;

   // timing
   localparam int CLK_MHZ = 50;
   localparam int DIAG_TIMEOUT_US = 1000;
   localparam int DIAG_TIMEOUT_CYC = DIAG_TIMEOUT_US * CLK_MHZ;

endpackage

// file: pcd_regs.sv
`timescale 1ns/1ps
`default_nettype none
// What this block does
// - a one written to the start bit launches a cable test and the bit reads one until the test ends.
// - the start bit reads zero once the test is done, and only then are the results to be trusted.
// - the two-bit outcome reads 00 normal, 01 open, 10 short.
// - an outcome of 11 means the test itself could not measure.
// - the near-short flag is set when the short lies within ten metres.
// - the nine-bit fault distance count, about 0.4 m per unit, resets to zero.
// - bit 5 shows receive polarity reversal and bit 4 the crossover state.
// - bit 3 forces link pass and bit 2, resetting to one, disables power saving.
// - bit 1 loops the receive line back onto the transmit line.
// - the second register mirrors the same fields at its own bit positions, all but the polarity and crossover bits.
// - the reserved range reads zero and ignores writes.
module pcd_regs
   import pcd_pkg::*;
#(
   parameter int TIMEOUT_CYC = DIAG_TIMEOUT_CYC
) (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic [12:0] avs_address,
   input wire logic avs_read,
   input wire logic avs_write,
   input wire logic [31:0] avs_writedata,
   input wire logic [3:0] avs_byteenable,
   output logic [31:0] avs_readdata,
   output logic avs_waitrequest,
   output logic irq,
   output logic diag_engine_start,
   input wire logic diag_engine_done,
   input wire logic diag_engine_valid,
   input wire logic [1:0] diag_engine_result,
   input wire logic diag_engine_short,
   input wire logic [CNT_W-1:0] diag_engine_count,
   input wire logic polarity_rev_in,
   input wire logic crossover_state_in,
   output logic force_link,
   output logic power_save_dis,
   output logic remote_loopback
);

   // the watchdog counter needs at least one cycle to count down from
   if (TIMEOUT_CYC < 1) begin : g_bad_timeout
      $error("TIMEOUT_CYC must be at least one");
   end

   // the count shares the mirror word with the controls from bit 9 up
   if (CNT_W > ALIAS_RLB_BIT) begin : g_bad_cnt_w
      $error("CNT_W overlaps the mirrored control bits");
   end

   // status and mask read back in the low bits of one word
   if (IRQ_W > 16 || IRQ_XOVER_BIT >= IRQ_W) begin : g_bad_irq_w
      $error("interrupt layout does not fit its register");
   end

   logic [10:0] idx;
   logic acc_live;
   logic wr_now;
   logic lo_en;
   logic hi_en;
   logic [15:0] wd;
   logic diag_busy;
   logic done_evt;
   logic [1:0] diag_result;
   logic diag_short;
   logic [CNT_W-1:0] diag_count;
   logic start_req;
   logic [1:0] line_sync1_reg;
   logic [1:0] line_sync2_reg;
   logic [1:0] line_prev_reg;
   logic [1:0] line_chg;
   logic [IRQ_W-1:0] irq_stat_reg;
   logic [IRQ_W-1:0] irq_mask_reg;
   logic [IRQ_W-1:0] irq_evt;
   logic [IRQ_W-1:0] irq_clr;
   logic [IRQ_W-1:0] irq_stat_next;
   logic [15:0] rd_next;
   logic [15:0] diag_word;
   logic [15:0] spec_word;
   logic [15:0] alias_word;
   logic sel_diag;
   logic sel_spec;
   logic sel_alias;
   logic sel_stat;
   logic sel_mask;
   logic diag_wr;
   logic spec_wr;
   logic alias_wr;
   logic stat_wr;
   logic mask_wr;

   assign idx = avs_address[12:2];
   assign acc_live = avs_read || avs_write;
   assign lo_en = avs_byteenable[0];
   assign hi_en = avs_byteenable[1];
   assign wd = avs_writedata[15:0];
   // writes land on the edge where the master sees waitrequest low
   assign wr_now = avs_write && !avs_waitrequest;

   // one decoder serves every write strobe, each gated by the lane its bits live in
   assign sel_diag = (idx == IDX_DIAG);
   assign sel_spec = (idx == IDX_SPEC);
   assign sel_alias = (idx == IDX_ALIAS);
   assign sel_stat = (idx == IDX_IRQ_STAT);
   assign sel_mask = (idx == IDX_IRQ_MASK);
   assign diag_wr = wr_now && sel_diag && hi_en;
   assign spec_wr = wr_now && sel_spec && lo_en;
   assign alias_wr = wr_now && sel_alias && hi_en;
   assign stat_wr = wr_now && sel_stat && lo_en;
   assign mask_wr = wr_now && sel_mask && lo_en;

   // one wait state, then a single cycle with waitrequest low
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         avs_waitrequest <= 1'b1;
      end else if (avs_waitrequest && acc_live) begin
         avs_waitrequest <= 1'b0;
      end else begin
         avs_waitrequest <= 1'b1;
      end
   end

   // line status comes from the analog side, so it is resynchronised first
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         line_sync1_reg <= 2'h0;
         line_sync2_reg <= 2'h0;
      end else begin
         line_sync1_reg <= {crossover_state_in, polarity_rev_in};
         line_sync2_reg <= line_sync1_reg;
      end
   end

   // history for the change detector; it resets to the idle level so reset makes no false edge
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         line_prev_reg <= 2'h0;
      end else begin
         line_prev_reg <= line_sync2_reg;
      end
   end

   assign line_chg = line_sync2_reg ^ line_prev_reg;

   // start is accepted from either alias; a write of zero never aborts a test
   always_comb begin
      start_req = 1'b0;
      if (diag_wr) begin
         start_req = wd[DIAG_START_BIT];
      end else if (alias_wr) begin
         start_req = wd[ALIAS_START_BIT];
      end
   end

   pcd_diag_ctl #(
      .TIMEOUT_CYC(TIMEOUT_CYC)
   ) u_diag (
      .clk(clk),
      .rst_n(rst_n),
      .start_req(start_req),
      .engine_done(diag_engine_done),
      .engine_valid(diag_engine_valid),
      .engine_result(diag_engine_result),
      .engine_short(diag_engine_short),
      .engine_count(diag_engine_count),
      .busy(diag_busy),
      .engine_start(diag_engine_start),
      .done_evt(done_evt),
      .result(diag_result),
      .near_short(diag_short),
      .fault_count(diag_count)
   );

   // both addresses steer the same three control flops, so they cannot disagree
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         force_link <= RST_FLINK;
         power_save_dis <= RST_PSAVE_DIS;
         remote_loopback <= RST_RLB;
      end else if (spec_wr) begin
         force_link <= wd[SPEC_FLINK_BIT];
         power_save_dis <= wd[SPEC_PSAVE_BIT];
         remote_loopback <= wd[SPEC_RLB_BIT];
      end else if (alias_wr) begin
         force_link <= wd[ALIAS_FLINK_BIT];
         power_save_dis <= wd[ALIAS_PSAVE_BIT];
         remote_loopback <= wd[ALIAS_RLB_BIT];
      end
   end

   // each line bit raises its own event when its synchronised level moves
   always_comb begin
      irq_evt = '0;
      irq_evt[IRQ_DONE_BIT] = done_evt;
      irq_evt[IRQ_POL_BIT] = line_chg[0];
      irq_evt[IRQ_XOVER_BIT] = line_chg[1];
   end

   always_comb begin
      irq_clr = '0;
      if (stat_wr) begin
         irq_clr = wd[IRQ_W-1:0];
      end
      // a new event in the clearing cycle survives
      irq_stat_next = (irq_stat_reg & ~irq_clr) | irq_evt;
   end

   always_ff @(posedge clk) begin
      if (!rst_n) begin
         irq_stat_reg <= RST_IRQ;
      end else begin
         irq_stat_reg <= irq_stat_next;
      end
   end

   // mask resets to zero so nothing interrupts before software opts in
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         irq_mask_reg <= RST_IRQ;
      end else if (mask_wr) begin
         irq_mask_reg <= wd[IRQ_W-1:0];
      end
   end

   // looking at the next status lets irq follow a set or clear on the same edge as the status
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         irq <= 1'b0;
      end else begin
         irq <= |(irq_stat_next & irq_mask_reg);
      end
   end

   always_comb begin
      diag_word = 16'h0000;
      diag_word[DIAG_START_BIT] = diag_busy;
      diag_word[DIAG_RES_LSB +: 2] = diag_result;
      diag_word[DIAG_SHORT_BIT] = diag_short;
      diag_word[DIAG_CNT_LSB +: CNT_W] = diag_count;
   end

   always_comb begin
      spec_word = 16'h0000;
      spec_word[SPEC_POL_BIT] = line_sync2_reg[0];
      spec_word[SPEC_XOVER_BIT] = line_sync2_reg[1];
      spec_word[SPEC_FLINK_BIT] = force_link;
      spec_word[SPEC_PSAVE_BIT] = power_save_dis;
      spec_word[SPEC_RLB_BIT] = remote_loopback;
   end

   always_comb begin
      alias_word = 16'h0000;
      alias_word[ALIAS_SHORT_BIT] = diag_short;
      alias_word[ALIAS_RES_LSB +: 2] = diag_result;
      alias_word[ALIAS_START_BIT] = diag_busy;
      alias_word[ALIAS_FLINK_BIT] = force_link;
      alias_word[ALIAS_PSAVE_BIT] = power_save_dis;
      alias_word[ALIAS_RLB_BIT] = remote_loopback;
      alias_word[ALIAS_CNT_LSB +: CNT_W] = diag_count;
   end

   always_comb begin
      rd_next = 16'h0000;
      case (idx)
         IDX_DIAG: begin
            rd_next = diag_word;
         end
         IDX_SPEC: begin
            rd_next = spec_word;
         end
         IDX_ALIAS: begin
            rd_next = alias_word;
         end
         IDX_IRQ_STAT: begin
            rd_next[IRQ_W-1:0] = irq_stat_reg;
         end
         IDX_IRQ_MASK: begin
            rd_next[IRQ_W-1:0] = irq_mask_reg;
         end
         IDX_RSV_LO, IDX_RSV_HI: begin
            rd_next = 16'h0000;
         end
         default: begin
            rd_next = 16'h0000;
         end
      endcase
   end

   // data is captured in the wait cycle and stands through the answering edge
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         avs_readdata <= 32'h0000_0000;
      end else if (avs_read && avs_waitrequest) begin
         avs_readdata <= {16'h0000, rd_next};
      end
   end

endmodule
`default_nettype wire

// file: pcd_regs_asserts.sv
`timescale 1ns/1ps
`default_nettype none
module pcd_regs_asserts
   import pcd_pkg::*;
(
   input wire logic clk,
   input wire logic rst_n,
   input wire logic [12:0] avs_address,
   input wire logic avs_read,
   input wire logic avs_write,
   input wire logic [31:0] avs_writedata,
   input wire logic [3:0] avs_byteenable,
   input wire logic [31:0] avs_readdata,
   input wire logic avs_waitrequest,
   input wire logic irq,
   input wire logic diag_engine_start,
   input wire logic force_link,
   input wire logic power_save_dis,
   input wire logic remote_loopback
);
   logic [10:0] idx;
   logic [2:0] ctl;
   assign idx = avs_address[12:2];
   assign ctl = {force_link, power_save_dis, remote_loopback};
   default clocking @(posedge clk); endclocking
   default disable iff (!rst_n);
   sequence s_wr; avs_write && !avs_waitrequest; endsequence
   sequence s_spec_wr; s_wr ##0 (idx == IDX_SPEC && avs_byteenable[0]); endsequence
   sequence s_alias_wr; s_wr ##0 (idx == IDX_ALIAS && avs_byteenable[1]); endsequence
   property p_wait_one; (avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest; endproperty
   property p_wait_pulse; !avs_waitrequest |=> avs_waitrequest; endproperty
   property p_rsv_zero;
      avs_read && avs_waitrequest && (idx == IDX_RSV_LO || idx == IDX_RSV_HI) |=> avs_readdata == 32'h0;
   endproperty
   property p_start_pulse; diag_engine_start |=> !diag_engine_start; endproperty
   property p_start_cause; $rose(diag_engine_start) |-> $past(avs_write && !avs_waitrequest); endproperty
   property p_spec_ctrl; s_spec_wr |=> ctl == $past(avs_writedata[3:1]); endproperty
   property p_alias_ctrl; s_alias_wr |=> ctl == $past(avs_writedata[11:9]); endproperty
   property p_ctrl_hold; !$stable(ctl) |-> $past(avs_write && !avs_waitrequest); endproperty
   property p_reset_out;
      $rose(rst_n) |-> avs_waitrequest && !irq && !diag_engine_start && ctl == 3'h2;
   endproperty
   a_wait_one: assert property (p_wait_one) else $error("no answer after one wait state");
   a_wait_pulse: assert property (p_wait_pulse) else $error("waitrequest low too long");
   a_rsv_zero: assert property (p_rsv_zero) else $error("reserved read not zero");
   a_start_pulse: assert property (p_start_pulse) else $error("start pulse too long");
   a_start_cause: assert property (p_start_cause) else $error("start without write");
   a_spec_ctrl: assert property (p_spec_ctrl) else $error("control write lost");
   a_alias_ctrl: assert property (p_alias_ctrl) else $error("mirror control write lost");
   a_ctrl_hold: assert property (p_ctrl_hold) else $error("control changed alone");
   a_reset_out: assert property (p_reset_out) else $error("bad output after reset");
endmodule
bind pcd_regs pcd_regs_asserts pcd_regs_asserts_inst (.*);
`default_nettype wire

// file: test_pcd_regs.sv
`timescale 1ns/1ps
`default_nettype none
module test_pcd_regs;
   import pcd_pkg::*;
   localparam int TO = 20;
   logic clk = 1'h0, rst_n = 1'h0, avs_read = 1'h0, avs_write = 1'h0;
   logic diag_engine_done = 1'h0, diag_engine_valid = 1'h0, diag_engine_short = 1'h0;
   logic polarity_rev_in = 1'h0, crossover_state_in = 1'h0;
   logic [12:0] avs_address = 13'h0;
   logic [31:0] avs_writedata = 32'h0;
   logic [3:0] avs_byteenable = 4'h0;
   logic [1:0] diag_engine_result = 2'h0;
   logic [CNT_W-1:0] diag_engine_count = 9'h0;
   logic [31:0] avs_readdata;
   logic avs_waitrequest, irq, diag_engine_start, force_link, power_save_dis, remote_loopback;
   integer seed = 32'h0A77D405, n_fail = 0, comparisons = 0, starts = 0, i, n;
   logic [15:0] d, x, e, m;
   logic [2:0] c = 3'h2;
   logic [1:0] pv = 2'h0;
   pcd_regs #(.TIMEOUT_CYC(TO)) pcd_regs_inst (.*);
   always #10 clk = ~clk;
   always @(posedge clk) if (diag_engine_start === 1'h1) starts <= starts + 1;
   task chk(input string s, input logic [15:0] ex, input logic [15:0] g);
      comparisons++;
      if (g !== ex) begin
         n_fail++;
         $display("BAD %s exp %h got %h", s, ex, g);
      end
   endtask
   // the request is held until the edge that samples waitrequest low
   task xfer(input logic w, input logic [10:0] a, input logic [15:0] v, input logic [3:0] be);
      n = 0;
      avs_address <= {a, 2'h0};
      avs_write <= w;
      avs_read <= !w;
      avs_writedata <= {16'h0, v};
      avs_byteenable <= be;
      @(posedge clk);
      while (avs_waitrequest !== 1'h0 && n < 20) begin
         n++;
         @(posedge clk);
      end
      if (avs_waitrequest !== 1'h0) begin
         n_fail++;
         $display("BAD waitrequest exp 0 got %b", avs_waitrequest);
      end
      d = avs_readdata[15:0];
      avs_read <= 1'h0;
      avs_write <= 1'h0;
      @(posedge clk);
   endtask
   task rc(input string s, input logic [10:0] a, input logic [15:0] ex, input logic [15:0] mk);
      xfer(1'h0, a, 16'h0, 4'h0);
      chk(s, ex & mk, d & mk);
   endtask
   function automatic logic [15:0] ediag(input logic v, input logic [1:0] r, input logic s,
                                         input logic [8:0] k);
      logic [1:0] q;
      q = v ? r : RES_FAILED;
      return {1'h0, q, s && q == RES_SHORT, 3'h0, v ? k : 9'h0};
   endfunction
   function automatic logic [15:0] ealias(input logic [15:0] g);
      return {g[12], g[14:13], g[15], c, g[8:0]};
   endfunction
   task end_of_test;
      $display("n_fail %0d comparisons %0d", n_fail, comparisons);
      if (n_fail == 0 && comparisons > 0)
         $display("Test passed");
      else
         $display("Test failed");
      $finish;
   endtask
   initial begin
      repeat (3) @(posedge clk);
      rst_n <= 1'h1;
      @(posedge clk);
      rc("diag", IDX_DIAG, 16'h0, 16'hFFFF);
      rc("alias", IDX_ALIAS, 16'h0400, 16'hFFFF);
      rc("mask", IDX_IRQ_MASK, 16'h0, 16'hFFFF);
      rc("none", 11'h001, 16'h0, 16'hFFFF);
      for (i = 0; i < 12; i++) begin
         x = 16'($random(seed));
         xfer(1'h1, i[0] ? IDX_ALIAS : IDX_SPEC, i[0] ? x & 16'hEFFF : x, {2'h0, x[5:4]});
         if (i[0] ? x[5] : x[4]) c = i[0] ? x[11:9] : x[3:1];
         xfer(1'h1, i[1] ? IDX_RSV_HI : IDX_RSV_LO, x, 4'h3);
         xfer(1'h1, IDX_DIAG, x & 16'h7FFF, 4'h3);
         rc("spec", IDX_SPEC, {12'h0, c, 1'h0}, 16'hFFFF);
         rc("alias", IDX_ALIAS, {4'h0, c, 9'h0}, 16'hFFFF);
         rc("rsv", i[1] ? IDX_RSV_HI : IDX_RSV_LO, 16'h0, 16'hFFFF);
         chk("ctl", {13'h0, c}, {13'h0, force_link, power_save_dis, remote_loopback});
         rc("diag", IDX_DIAG, 16'h0, 16'hFFFF);
      end
      rst_n <= 1'h0;
      repeat (2) @(posedge clk);
      rst_n <= 1'h1;
      @(posedge clk);
      c = 3'h2;
      rc("spec", IDX_SPEC, 16'h0004, 16'hFFFF);
      for (i = 0; i < 6; i++) begin
         x = 16'($random(seed));
         xfer(1'h1, IDX_IRQ_MASK, {15'h0, i != 2}, 4'h1);
         xfer(1'h1, i[0] ? IDX_ALIAS : IDX_DIAG, i[0] ? {4'h1, c, 9'h0} : 16'h8000, 4'h2);
         rc("busy", IDX_DIAG, 16'h8000, 16'h8000);
         xfer(1'h1, IDX_DIAG, 16'h8000, 4'h2);
         if (i < 5) begin
            diag_engine_done <= 1'h1;
            diag_engine_valid <= i != 4;
            diag_engine_result <= i[1:0];
            diag_engine_short <= i != 3;
            diag_engine_count <= x[8:0];
            @(posedge clk);
            diag_engine_done <= 1'h0;
            diag_engine_result <= ~i[1:0];
            diag_engine_count <= ~x[8:0];
         end else
            repeat (TO + 4) @(posedge clk);
         repeat (3) @(posedge clk);
         e = ediag(i < 4, i[1:0], i != 3, x[8:0]);
         m = i == 4 ? 16'hFE00 : 16'hFFFF;
         rc("diag", IDX_DIAG, e, m);
         rc("alias", IDX_ALIAS, ealias(e), m);
         chk("irq", {15'h0, i != 2}, {15'h0, irq});
         rc("stat", IDX_IRQ_STAT, 16'h0001, 16'hFFFF);
         xfer(1'h1, IDX_IRQ_STAT, 16'h0001, 4'h1);
         chk("irq0", 16'h0, {15'h0, irq});
         rc("hold", IDX_DIAG, e, m);
      end
      chk("starts", 16'h0006, starts[15:0]);
      diag_engine_done <= 1'h1;
      diag_engine_valid <= 1'h1;
      diag_engine_result <= RES_OPEN;
      @(posedge clk);
      diag_engine_done <= 1'h0;
      rc("idle", IDX_DIAG, e, m);
      rc("idst", IDX_IRQ_STAT, 16'h0, 16'hFFFF);
      xfer(1'h1, IDX_IRQ_MASK, 16'h0007, 4'h1);
      for (i = 0; i < 6; i++) begin
         x = 16'($random(seed));
         polarity_rev_in <= x[0];
         crossover_state_in <= x[1];
         repeat (5) @(posedge clk);
         rc("pol", IDX_SPEC, {10'h0, x[0], x[1], c, 1'h0}, 16'hFFFF);
         chk("irqp", {15'h0, |(x[1:0] ^ pv)}, {15'h0, irq});
         rc("pstat", IDX_IRQ_STAT, {13'h0, x[1:0] ^ pv, 1'h0}, 16'hFFFF);
         xfer(1'h1, IDX_IRQ_STAT, 16'h0007, 4'h1);
         pv = x[1:0];
      end
      end_of_test;
   end
   // the run needs under a thousand cycles; the 50000-cycle limit leaves ample margin
   initial begin
      #1000000;
      $display("BAD watchdog exp finish got timeout");
      n_fail++;
      end_of_test;
   end
endmodule
`default_nettype wire
